/* File: include/nvx_consts.vh */
`ifndef NVX_CONSTS_VH
`define NVX_CONSTS_VH
// register offsets
`define NVX_ADDR_PULLUP_LOW 8'hF0
`define NVX_ADDR_PULLUP_HIGH 8'hF1
`define NVX_ADDR_OUTCTL_LOW 8'hF2
`define NVX_ADDR_OUTCTL_HIGH 8'hF3
`define NVX_ADDR_CONFIG 8'hF4
`define NVX_ADDR_LEVEL_LOW 8'hF8
`define NVX_ADDR_LEVEL_HIGH 8'hF9
// region bounds
`define NVX_USER_EE_LAST 8'h3F
`define NVX_UPPER_EE_FIRST 8'hF5
`define NVX_UPPER_EE_LAST 8'hF7
`define NVX_SRAM_FIRST 8'hFA
// reset values
`define NVX_RST_PULLUP 8'h00
`define NVX_RST_OUTCTL_LOW 8'hFF
`define NVX_RST_OUTCTL_HIGH 8'h01
`define NVX_RST_CONFIG 8'h00
// fixed upper slave address bits
`define NVX_FIXED_ADDR 4'hA
// eeprom program time in microseconds, clock in MHz
`define NVX_PROG_TIME_US 10000
`define NVX_CLK_MHZ 50
`define NVX_PROG_CYCLES (`NVX_PROG_TIME_US * `NVX_CLK_MHZ)
`define NVX_ROW_MASK 8'hF8
`define NVX_COL_MASK 8'h07
`define NVX_BIT_LAST 4'h8
`endif

/* File: src/nvx_io_expander.v */
`timescale 1ns/100ps
`include "nvx_consts.vh"
module nvx_io_expander #(
  parameter PROG_CYCLES = `NVX_PROG_CYCLES
) (
  input wire clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire addr_select_bit0,
  input wire addr_select_bit1,
  input wire addr_select_bit2,
  input wire [8:0] pin_in,
  output reg [8:0] pin_out,
  output reg [8:0] pin_oe,
  output reg [8:0] pin_pullup,
  output reg prog_busy
);

  // ****************************************
  // synchronisers
  // ****************************************
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [8:0] pin_meta;
  reg [8:0] pin_level;
  reg [2:0] asel_meta;
  reg [2:0] asel;
  reg scl_d;
  reg sda_d;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      pin_meta <= 9'h000;
      pin_level <= 9'h000;
      asel_meta <= 3'h0;
      asel <= 3'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      pin_meta <= pin_in;
      pin_level <= pin_meta;
      asel_meta <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
      asel <= asel_meta;
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  // bus edges show up two clocks late, so each scl level must last several clk
  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  // scl high on both samples, so an scl edge is never taken for start or stop
  wire start_det = scl & scl_d & sda_d & ~sda;
  wire stop_det = scl & scl_d & ~sda_d & sda;
  wire [6:0] own_addr = {`NVX_FIXED_ADDR, asel};

  // ****************************************
  // storage
  // ****************************************
  reg [7:0] user_ee [0:63];
  reg [7:0] upper_ee [0:2];
  reg [7:0] user_sram [0:5];
  reg [7:0] pullup_low;
  reg [7:0] pullup_high;
  reg [7:0] outctl_low;
  reg [7:0] outctl_high;
  reg [7:0] config_reg;
  // eeprom copies of the shadowed registers survive reset
  reg [7:0] ee_pullup_low;
  reg [7:0] ee_pullup_high;
  reg [7:0] ee_outctl_low;
  reg [7:0] ee_outctl_high;
  reg [7:0] ee_config;
  reg loaded;

  // ****************************************
  // bus state machine
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_DEVADDR = 3'h1;
  localparam ST_MEMADDR = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_RACK = 3'h5;

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] mem_addr;
  reg ack_phase;
  reg ack_pend;
  reg prog_pend;
  reg [31:0] prog_cnt;
  reg [7:0] rd_byte;

  // read mux; undefined places read zero
  always @* begin
    rd_byte = 8'h00;
    if (mem_addr <= `NVX_USER_EE_LAST) begin
      rd_byte = user_ee[mem_addr[5:0]];
    end else if (mem_addr >= `NVX_UPPER_EE_FIRST && mem_addr <= `NVX_UPPER_EE_LAST) begin
      rd_byte = upper_ee[mem_addr[1:0] - 2'h1];
    end else if (mem_addr >= `NVX_SRAM_FIRST) begin
      rd_byte = user_sram[mem_addr[2:0] - 3'h2];
    end else begin
      case (mem_addr)
        `NVX_ADDR_PULLUP_LOW: rd_byte = pullup_low;
        `NVX_ADDR_PULLUP_HIGH: rd_byte = pullup_high;
        `NVX_ADDR_OUTCTL_LOW: rd_byte = outctl_low;
        `NVX_ADDR_OUTCTL_HIGH: rd_byte = outctl_high;
        `NVX_ADDR_CONFIG: rd_byte = config_reg;
        `NVX_ADDR_LEVEL_LOW: rd_byte = pin_level[7:0];
        `NVX_ADDR_LEVEL_HIGH: rd_byte = {7'h00, pin_level[8]};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  wire [7:0] next_addr_wr = (mem_addr & `NVX_ROW_MASK) |
    ((mem_addr + 8'h01) & `NVX_COL_MASK);
  wire [7:0] rx_byte = {shift[6:0], sda};
  wire ee_backed = (mem_addr <= `NVX_USER_EE_LAST) ||
    (mem_addr >= `NVX_UPPER_EE_FIRST && mem_addr <= `NVX_UPPER_EE_LAST);
  wire shadowed = (mem_addr >= `NVX_ADDR_PULLUP_LOW && mem_addr <= `NVX_ADDR_CONFIG);
  wire write_through = ~config_reg[0];
  integer i;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      mem_addr <= 8'h00;
      ack_phase <= 1'b0;
      ack_pend <= 1'b0;
      prog_pend <= 1'b0;
      prog_cnt <= 32'h0;
      prog_busy <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      pullup_low <= `NVX_RST_PULLUP;
      pullup_high <= `NVX_RST_PULLUP;
      outctl_low <= `NVX_RST_OUTCTL_LOW;
      outctl_high <= `NVX_RST_OUTCTL_HIGH;
      config_reg <= `NVX_RST_CONFIG;
      loaded <= 1'b0;
    end else begin
      // first cycle after reset: shadows take their eeprom copies
      if (!loaded) begin
        loaded <= 1'b1;
        pullup_low <= ee_pullup_low;
        pullup_high <= {7'h00, ee_pullup_high[0]};
        outctl_low <= ee_outctl_low;
        outctl_high <= {7'h00, ee_outctl_high[0]};
        config_reg <= {7'h00, ee_config[0]};
      end
      // program cycle starts at the stop or repeated start that ends a nonvolatile write
      // a stop while busy leaves the counter running rather than restarting it
      if (prog_busy) begin
        if (prog_cnt == 32'h0) begin
          prog_busy <= 1'b0;
        end else begin
          prog_cnt <= prog_cnt - 32'h1;
        end
      end
      if (start_det) begin
        state <= ST_DEVADDR;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
        if (prog_pend) begin
          prog_pend <= 1'b0;
          prog_busy <= 1'b1;
          prog_cnt <= PROG_CYCLES - 1;
        end
      end else if (stop_det) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        if (prog_pend) begin
          prog_pend <= 1'b0;
          prog_busy <= 1'b1;
          prog_cnt <= PROG_CYCLES - 1;
        end
      end else if (state != ST_IDLE) begin
        if (scl_fall) begin
          // drive on scl low: ack after 8 bits, data before each bit
          if (ack_pend) begin
            ack_pend <= 1'b0;
            sda_oe <= 1'b1;
            sda_out <= 1'b0;
          end else if (state == ST_RDATA && !ack_phase) begin
            sda_oe <= ~shift[7];
            sda_out <= 1'b0;
          end else begin
            // every other low phase belongs to the master: the bits of a written
            // byte, and the master's own ack bit in a read
            sda_oe <= 1'b0;
          end
        end
        if (scl_rise) begin
          if (ack_phase) begin
            ack_phase <= 1'b0;
            bit_cnt <= 4'h0;
            if (state == ST_RACK) begin
              if (sda) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_RDATA;
                shift <= rd_byte;
              end
            end else if (state == ST_RDATA) begin
              shift <= rd_byte;
            end
          end else if (state == ST_RDATA) begin
            shift <= {shift[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `NVX_BIT_LAST - 4'h1) begin
              state <= ST_RACK;
              mem_addr <= mem_addr + 8'h01;
              ack_phase <= 1'b1;
            end
          end else begin
            shift <= rx_byte;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `NVX_BIT_LAST - 4'h1) begin
              ack_phase <= 1'b1;
              ack_pend <= 1'b1;
              case (state)
                ST_DEVADDR: begin
                  if (rx_byte[7:1] != own_addr || prog_busy) begin
                    state <= ST_IDLE;
                    ack_pend <= 1'b0;
                  end else if (rx_byte[0]) begin
                    state <= ST_RDATA;
                    shift <= rd_byte;
                  end else begin
                    state <= ST_MEMADDR;
                  end
                end
                ST_MEMADDR: begin
                  mem_addr <= rx_byte;
                  state <= ST_WDATA;
                end
                ST_WDATA: begin
                  mem_addr <= next_addr_wr;
                  if (ee_backed || (shadowed && write_through)) begin
                    prog_pend <= 1'b1;
                  end
                  case (mem_addr)
                    `NVX_ADDR_PULLUP_LOW: pullup_low <= rx_byte;
                    `NVX_ADDR_PULLUP_HIGH: pullup_high <= {7'h00, rx_byte[0]};
                    `NVX_ADDR_OUTCTL_LOW: outctl_low <= rx_byte;
                    `NVX_ADDR_OUTCTL_HIGH: outctl_high <= {7'h00, rx_byte[0]};
                    `NVX_ADDR_CONFIG: config_reg <= {7'h00, rx_byte[0]};
                    default: config_reg <= config_reg;
                  endcase
                end
                default: state <= ST_IDLE;
              endcase
            end
          end
        end
      end
    end
  end

  // ****************************************
  // nonvolatile arrays and sram, no reset
  // ****************************************
  // same qualifiers as the state machine, so arrays and shadows agree on a cut frame
  wire wr_now = (state == ST_WDATA) && scl_rise && !ack_phase &&
    !start_det && !stop_det && (bit_cnt == `NVX_BIT_LAST - 4'h1);

  always @(posedge clk) begin
    if (wr_now) begin
      if (mem_addr <= `NVX_USER_EE_LAST) begin
        user_ee[mem_addr[5:0]] <= rx_byte;
      end else if (mem_addr >= `NVX_UPPER_EE_FIRST && mem_addr <= `NVX_UPPER_EE_LAST) begin
        upper_ee[mem_addr[1:0] - 2'h1] <= rx_byte;
      end else if (mem_addr >= `NVX_SRAM_FIRST) begin
        user_sram[mem_addr[2:0] - 3'h2] <= rx_byte;
      end
      if (write_through) begin
        case (mem_addr)
          `NVX_ADDR_PULLUP_LOW: ee_pullup_low <= rx_byte;
          `NVX_ADDR_PULLUP_HIGH: ee_pullup_high <= rx_byte;
          `NVX_ADDR_OUTCTL_LOW: ee_outctl_low <= rx_byte;
          `NVX_ADDR_OUTCTL_HIGH: ee_outctl_high <= rx_byte;
          `NVX_ADDR_CONFIG: ee_config <= rx_byte;
          default: ee_config <= ee_config;
        endcase
      end
    end
  end

  // factory contents for simulation
  // no reset on these: they stand for cells that keep their value
  initial begin
    for (i = 0; i < 64; i = i + 1) begin
      user_ee[i] = 8'h00;
    end
    for (i = 0; i < 3; i = i + 1) begin
      upper_ee[i] = 8'h00;
    end
    for (i = 0; i < 6; i = i + 1) begin
      user_sram[i] = 8'h00;
    end
    ee_pullup_low = `NVX_RST_PULLUP;
    ee_pullup_high = `NVX_RST_PULLUP;
    ee_outctl_low = `NVX_RST_OUTCTL_LOW;
    ee_outctl_high = `NVX_RST_OUTCTL_HIGH;
    ee_config = `NVX_RST_CONFIG;
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // pin data stays low; the pins are open drain and only the enable and the pull-up move
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_pin
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_out[g] <= 1'b0;
          pin_oe[g] <= 1'b0;
          pin_pullup[g] <= 1'b0;
        end else begin
          pin_out[g] <= 1'b0;
          pin_oe[g] <= (g < 8) ? ~outctl_low[g % 8] : ~outctl_high[0];
          pin_pullup[g] <= (g < 8) ? pullup_low[g % 8] : pullup_high[0];
        end
      end
    end
  endgenerate

endmodule

/* File: dv/nvx_io_expander_sva.sv */
`timescale 1ns/100ps
// ************************************************
// port checks
// ************************************************
module nvx_io_expander_sva #(
  parameter PROG_CYCLES = 50
) (
  input wire clk,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire addr_select_bit0,
  input wire addr_select_bit1,
  input wire addr_select_bit2,
  input wire [8:0] pin_in,
  input wire [8:0] pin_out,
  input wire [8:0] pin_oe,
  input wire [8:0] pin_pullup,
  input wire prog_busy
);
  int busy_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a driven bit must outlast the rest of the low phase and the whole high phase
  sequence bit_held;
    sda_oe [*6];
  endsequence
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) busy_cnt <= 0;
    else if (prog_busy) busy_cnt <= busy_cnt + 1;
    else busy_cnt <= 0;
  end
  pin_low_only_a: assert property (pin_out == 9'h000) else $error("pin data not low");
  sda_low_only_a: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
  busy_len_a: assert property ($fell(prog_busy) |-> busy_cnt >= PROG_CYCLES - 1 &&
    busy_cnt <= PROG_CYCLES + 1) else $error("program cycle length wrong");
  busy_max_a: assert property (busy_cnt <= PROG_CYCLES + 1) else $error("program too long");
  busy_no_ack_a: assert property (prog_busy |-> !$rose(sda_oe)) else $error("ack while busy");
  busy_pins_a: assert property (prog_busy && $past(prog_busy) |->
    $stable(pin_oe) && $stable(pin_pullup)) else $error("pins changed while busy");
  scl_high_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  bit_hold_a: assert property ($rose(sda_oe) |-> bit_held) else $error("bit too short");
  busy_at_stop_a: assert property ($rose(prog_busy) |-> scl_in) else $error("busy not at stop");
endmodule
bind nvx_io_expander nvx_io_expander_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .addr_select_bit0(addr_select_bit0), .addr_select_bit1(addr_select_bit1),
  .addr_select_bit2(addr_select_bit2), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup(pin_pullup), .prog_busy(prog_busy));

/* File: dv/nvx_i2c_master.sv */
`timescale 1ns/100ps
// ************************************************
// bus master model, 160 ns bit time
// ************************************************
module nvx_i2c_master (
  input wire sda,
  output logic scl,
  output logic sda_low
);
  logic [7:0] res;
  logic r;
  event res_ev;
  // scl stands high between frames; sda released shows the pull-up level
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bitx(input logic b, output logic v);
    #40 sda_low = ~b;
    #40 scl = 1'b1;
    #40 v = sda;
    #40 scl = 1'b0;
  endtask
  task automatic start;
    #40 sda_low = 1'b0;
    #40 scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic stop;
    #40 sda_low = 1'b1;
    #40 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask
  task automatic wbyte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    res = {7'h00, r};
    -> res_ev;
  endtask
  task automatic rbyte(input logic last);
    for (int i = 7; i >= 0; i--) bitx(1'b1, res[i]);
    bitx(last, r);
    -> res_ev;
  endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  localparam int PROG = 200;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [8:0] ext = 9'h1FF;
  logic [6:0] dev;
  logic [7:0] d, e, s;
  logic [23:0] r3;
  logic [15:0] q;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  wire scl, sda_low, sda_out, sda_oe, prog_busy;
  wire [8:0] pin_out, pin_oe, pin_pullup;
  wire sda = ~(sda_low | sda_oe);
  wire [8:0] pin_in = ext & ~pin_oe;
  always #10 clk = ~clk;
  nvx_io_expander #(.PROG_CYCLES(PROG)) dut (
    .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
    .addr_select_bit2(sel[2]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .prog_busy(prog_busy));
  nvx_i2c_master m (.sda(sda), .scl(scl), .sda_low(sda_low));
  // ************************************************
  // shared tasks
  // ************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic ex(input logic [7:0] v, input logic [7:0] mk);
    exp_q.push_back({mk, v});
  endtask
  // mask 00 marks acks whose value the rules leave open
  task automatic wr(input logic [7:0] ma, input logic [23:0] w, input int n, input logic [7:0] mk);
    ex(8'h00, 8'hFF);
    m.start();
    m.wbyte({dev, 1'b0});
    ex(8'h00, mk);
    m.wbyte(ma);
    for (int i = 0; i < n; i++) begin
      ex(8'h00, mk);
      m.wbyte(w[23 - 8 * i -: 8]);
    end
    m.stop();
  endtask
  task automatic rd(input logic [7:0] ma, input logic [39:0] w, input int n);
    ex(8'h00, 8'hFF);
    m.start();
    m.wbyte({dev, 1'b0});
    ex(8'h00, 8'hFF);
    m.wbyte(ma);
    ex(8'h00, 8'hFF);
    m.start();
    m.wbyte({dev, 1'b1});
    for (int i = 0; i < n; i++) begin
      ex(w[39 - 8 * i -: 8], 8'hFF);
      m.rbyte(i == n - 1);
    end
    m.stop();
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 4 * PROG && prog_busy !== 1'b0; i++) @(negedge clk);
    check({7'h00, prog_busy}, 8'h00);
  endtask
  initial forever begin
    @(m.res_ev);
    q = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFF00;
    check(m.res & q[15:8], q[7:0] & q[15:8]);
  end
  initial begin
    #1000000;
    num_errors++;
    stop_test();
  end
  // ************************************************
  // scenarios
  // ************************************************
  initial begin
    d = 8'($urandom(32'h865E));
    e = 8'($urandom);
    s = 8'($urandom);
    r3 = 24'($urandom);
    @(negedge clk);
    sel = 3'($urandom);
    dev = {4'hA, sel};
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    check(pin_oe[7:0] | pin_pullup[7:0], 8'h00);
    rd(8'hF4, 40'h0, 1);
    wr(8'hF0, {d, 16'h0000}, 1, 8'hFF);
    check(pin_pullup[7:0], d);
    check({7'h00, prog_busy}, 8'h01);
    ex(8'h01, 8'hFF);
    m.start();
    m.wbyte({dev, 1'b0});
    m.stop();
    wait_idle();
    wr(8'hF4, 24'h010000, 1, 8'hFF);
    wait_idle();
    wr(8'hF2, {e, 16'h0000}, 2, 8'hFF);
    check({7'h00, prog_busy}, 8'h00);
    check(pin_oe[7:0], ~e);
    check({7'h00, pin_oe[8]}, 8'h01);
    rd(8'hF0, {d, 8'h00, e, 8'h00, 8'h01}, 5);
    ext = 9'($urandom);
    wr(8'hF8, {~d, 16'h0000}, 1, 8'h00);
    rd(8'hF8, {ext[7:0] & e, 32'h00000000}, 2);
    wr(8'h06, r3, 3, 8'hFF);
    wait_idle();
    rd(8'h06, {r3[23:8], 24'h000000}, 2);
    rd(8'h00, {r3[7:0], 32'h00000000}, 1);
    wr(8'hFA, {s, 16'h0000}, 1, 8'hFF);
    wr(8'h80, {~s, 16'h0000}, 1, 8'h00);
    check({7'h00, prog_busy}, 8'h00);
    rd(8'hFA, {s, 32'h00000000}, 1);
    ex(8'h01, 8'hFF);
    ex(8'h01, 8'hFF);
    m.start();
    m.wbyte({dev ^ 7'h01, 1'b0});
    m.wbyte(8'hF2);
    m.stop();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    check(pin_pullup[7:0], d);
    check(pin_oe[7:0], 8'h00);
    rd(8'hF4, 40'h0100000000, 1);
    check(8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule
